/* hdl/pdm_consts.svh */
// Timing and layout constants for the path delay measurement block.
// Assumes inclusion by bare name from design and bench files.
`ifndef PDM_CONSTS_SVH
`define PDM_CONSTS_SVH

// ****************************************
// Clock and accuracy figures
// ****************************************
`define PDM_CLK_PERIOD_PS       5000
`define PDM_DL_ACCURACY_PS      8138
`define PDM_RT_ACCURACY_PS      16276
`define PDM_DL_ACCURACY_CYC     ((`PDM_DL_ACCURACY_PS) / (`PDM_CLK_PERIOD_PS))
`define PDM_RT_ACCURACY_CYC     ((`PDM_RT_ACCURACY_PS) / (`PDM_CLK_PERIOD_PS))

// ****************************************
// Widths, fixed latencies, buffer depth and reset values
// ****************************************
`define PDM_DATA_W              32
`define PDM_RTD_W               20
`define PDM_CAL_W               4
`define PDM_RTD_RESET           20'h00000
`define PDM_RX_FIXED_LAT        4
`define PDM_TX_FIXED_LAT        3
`define PDM_EBUF_DEPTH          8
`define PDM_EBUF_AW             3

`endif

/* hdl/pdm_pkg.sv */
// Types shared by both ends of the path delay measurement link.
// Assumes the constants header is compiled alongside.
`include "pdm_consts.svh"
package pdm_pkg;

   typedef enum logic [1:0] {
      PDM_ROLE_SLAVE    = 2'b00,
      PDM_ROLE_MASTER   = 2'b01,
      PDM_ROLE_RE_SLAVE = 2'b10
   } pdm_role_t;

   typedef enum logic [1:0] {
      PDM_RT_IDLE  = 2'b00,
      PDM_RT_COUNT = 2'b01,
      PDM_RT_DONE  = 2'b10
   } pdm_rt_state_t;

endpackage

/* hdl/pdm_link_if.sv */
// Line interface between a measuring endpoint and its link partner.
// Assumes both ends share clk_sys_i; the bench joins them.
`timescale 1ns/1ps
`include "pdm_consts.svh"
interface pdm_link_if;
   logic [`PDM_DATA_W-1:0] dl_data;
   logic                   dl_frame;
   logic [`PDM_DATA_W-1:0] ul_data;
   logic                   ul_frame;

   modport endpoint (output dl_data, output dl_frame, input ul_data, input ul_frame);
   modport partner  (input dl_data, input dl_frame, output ul_data, output ul_frame);
endinterface

/* hdl/pdm_partner.sv */
// Link partner: receives downlink frames and loops them back uplink.
// Assumes a fixed turnaround and a shared core clock.
`timescale 1ns/1ps
`include "pdm_consts.svh"
module pdm_partner
   import pdm_pkg::*;
#(
   parameter int LOOP_LAT = 2
) (
   // Clock and reset
   input  wire logic                   clk_sys_i,
   input  wire logic                   reset_n_i,
   input  wire logic                   clk_en_i,
   // Link
   pdm_link_if.partner                 link,
   // User side
   output logic      [`PDM_DATA_W-1:0] rx_data_o,
   output logic                        rx_frame_o
);

   // ****************************************
   // Loopback turnaround pipeline
   // ****************************************
   logic [LOOP_LAT-1:0][`PDM_DATA_W:0] pipe_q, pipe_d;
   logic [`PDM_DATA_W-1:0]             rx_data_q, rx_data_d;
   logic                               rx_frame_q, rx_frame_d;

   always_comb begin
      pipe_d     = pipe_q;
      rx_data_d  = rx_data_q;
      rx_frame_d = rx_frame_q;
      if (clk_en_i) begin
         pipe_d[0]  = {link.dl_frame, link.dl_data};
         for (int i = 1; i < LOOP_LAT; i++) begin
            pipe_d[i] = pipe_q[i-1];
         end
         rx_data_d  = link.dl_data;
         rx_frame_d = link.dl_frame;
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pipe_q     <= '0;
         rx_data_q  <= '0;
         rx_frame_q <= 1'b0;
      end else begin
         pipe_q     <= pipe_d;
         rx_data_q  <= rx_data_d;
         rx_frame_q <= rx_frame_d;
      end
   end

   assign link.ul_frame = pipe_q[LOOP_LAT-1][`PDM_DATA_W];
   assign link.ul_data  = pipe_q[LOOP_LAT-1][`PDM_DATA_W-1:0];
   assign rx_data_o     = rx_data_q;
   assign rx_frame_o    = rx_frame_q;

endmodule

/* hdl/pdm_endpoint.sv */
// Contract
// [RL1] Nonzero byte offset adds one receive cycle
// [RL2] Receive transceiver latency fixed per configuration
// [RL3] Receive elastic buffer adds variable delay
// [RL4] Single-trip delay inserted only as slave
// [RL5] Round-trip pipeline delay only as master
// [RL6] Transmit elastic buffer adds variable delay
// [RL7] Bitslip delay only as radio equipment slave
// [RL8] Receive delay: line frame to aux frame
// [RL9] Transmit delay: aux frame to line frame
// [RL10] Master measures frame round trip, reports it
// [RL11] Downlink delay within 8.138 ns
// [RL12] Round trip within 16.276 ns
// [RL13] Controller reads round trip periodically
// [RL14] Controller sums hops, drops inner loopbacks
// [RL15] Round trip counts cycles, updates per frame
//
// Measuring endpoint: transmit and receive paths with delay accounting.
// Assumes the partner on the link shares clk_sys_i.
`timescale 1ns/1ps
`include "pdm_consts.svh"
module pdm_endpoint
   import pdm_pkg::*;
#(
   parameter int RX_FIXED = `PDM_RX_FIXED_LAT,
   parameter int TX_FIXED = `PDM_TX_FIXED_LAT,
   parameter int CAL_W    = `PDM_CAL_W,
   parameter int RTD_W    = `PDM_RTD_W
) (
   // Clock and reset
   input  wire logic                   clk_sys_i,
   input  wire logic                   reset_n_i,
   input  wire logic                   clk_en_i,
   // Configuration
   input  wire pdm_role_t              role_i,
   input  wire logic                   st_cal_en_i,
   input  wire logic                   rt_cal_en_i,
   input  wire logic       [CAL_W-1:0] st_cal_dly_i,
   input  wire logic       [CAL_W-1:0] rt_cal_dly_i,
   input  wire logic       [CAL_W-1:0] tx_ebuf_dly_i,
   input  wire logic       [CAL_W-1:0] rx_ebuf_dly_i,
   input  wire logic       [CAL_W-1:0] bitslip_dly_i,
   input  wire logic             [1:0] byte_ofs_i,
   // Auxiliary frame port
   input  wire logic [`PDM_DATA_W-1:0] aux_tx_data_i,
   input  wire logic                   aux_tx_frame_i,
   output logic      [`PDM_DATA_W-1:0] aux_rx_data_o,
   output logic                        aux_rx_frame_o,
   // Status
   output logic                  [1:0] byte_delay_o,
   output logic            [RTD_W-1:0] round_trip_delay_o,
   output logic                        round_trip_valid_o,
   // Link
   pdm_link_if.endpoint                link
);

   localparam int DW    = `PDM_DATA_W + 1;
   localparam int DEPTH = 1 << CAL_W;

   // ****************************************
   // Variable delay line function
   // ****************************************
   function automatic logic [DW-1:0] tap(input logic [DEPTH-1:0][DW-1:0] line,
                                         input logic [CAL_W-1:0] sel,
                                         input logic [DW-1:0] head);
      tap = (sel == '0) ? head : line[sel - 1'b1];
   endfunction

   // ****************************************
   // Transmit path: fixed, elastic, bitslip
   // ****************************************
   logic [TX_FIXED-1:0][DW-1:0] tx_fix_q, tx_fix_d;
   logic [DEPTH-1:0][DW-1:0]    tx_eb_q, tx_eb_d;
   logic [DEPTH-1:0][DW-1:0]    tx_bs_q, tx_bs_d;
   logic [DW-1:0]               tx_eb_out, tx_bs_out, tx_line_q, tx_line_d;
   logic [CAL_W-1:0]            bs_sel;

   // Bitslip only for radio equipment slave
   assign bs_sel    = (role_i == PDM_ROLE_RE_SLAVE) ? bitslip_dly_i : '0; // see [RL7]
   assign tx_eb_out = tap(tx_eb_q, tx_ebuf_dly_i, tx_fix_q[TX_FIXED-1]); // see [RL6]
   assign tx_bs_out = tap(tx_bs_q, bs_sel, tx_eb_out);

   always_comb begin
      tx_fix_d  = tx_fix_q;
      tx_eb_d   = tx_eb_q;
      tx_bs_d   = tx_bs_q;
      tx_line_d = tx_line_q;
      if (clk_en_i) begin
         // Aux frame start to line frame start
         tx_fix_d[0] = {aux_tx_frame_i, aux_tx_data_i}; // see [RL9]
         for (int i = 1; i < TX_FIXED; i++) begin
            tx_fix_d[i] = tx_fix_q[i-1];
         end
         tx_eb_d[0] = tx_fix_q[TX_FIXED-1];
         tx_bs_d[0] = tx_eb_out;
         for (int i = 1; i < DEPTH; i++) begin
            tx_eb_d[i] = tx_eb_q[i-1];
            tx_bs_d[i] = tx_bs_q[i-1];
         end
         tx_line_d = tx_bs_out; // see [RL11]
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tx_fix_q  <= '0;
         tx_eb_q   <= '0;
         tx_bs_q   <= '0;
         tx_line_q <= '0;
      end else begin
         tx_fix_q  <= tx_fix_d;
         tx_eb_q   <= tx_eb_d;
         tx_bs_q   <= tx_bs_d;
         tx_line_q <= tx_line_d;
      end
   end

   assign link.dl_frame = tx_line_q[`PDM_DATA_W];
   assign link.dl_data  = tx_line_q[`PDM_DATA_W-1:0];

   // ****************************************
   // Receive path: sync, fixed, elastic, byte, calibration
   // ****************************************
   logic [DW-1:0]               rx_s1_q, rx_s2_q, rx_s1_d, rx_s2_d;
   logic [RX_FIXED-1:0][DW-1:0] rx_fix_q, rx_fix_d;
   logic [DEPTH-1:0][DW-1:0]    rx_eb_q, rx_eb_d;
   logic [DW-1:0]               rx_byte_q, rx_byte_d;
   logic [DEPTH-1:0][DW-1:0]    rx_cal_q, rx_cal_d;
   logic [DW-1:0]               rx_eb_out, rx_by_out, rx_cal_out, aux_q, aux_d;
   logic [CAL_W-1:0]            cal_sel;
   logic [1:0]                  byte_q, byte_d;

   // Calibration delay chosen by role
   always_comb begin
      cal_sel = '0;
      if (st_cal_en_i && role_i != PDM_ROLE_MASTER) begin
         cal_sel = st_cal_dly_i; // see [RL4]
      end else if (rt_cal_en_i && role_i == PDM_ROLE_MASTER) begin
         cal_sel = rt_cal_dly_i; // see [RL5]
      end
   end

   assign rx_eb_out  = tap(rx_eb_q, rx_ebuf_dly_i, rx_fix_q[RX_FIXED-1]); // see [RL3]
   // Extra cycle when byte offset nonzero
   assign rx_by_out  = (byte_q != 2'h0) ? rx_byte_q : rx_eb_out; // see [RL1]
   assign rx_cal_out = tap(rx_cal_q, cal_sel, rx_by_out);

   always_comb begin
      rx_s1_d   = rx_s1_q;
      rx_s2_d   = rx_s2_q;
      rx_fix_d  = rx_fix_q;
      rx_eb_d   = rx_eb_q;
      rx_byte_d = rx_byte_q;
      rx_cal_d  = rx_cal_q;
      aux_d     = aux_q;
      byte_d    = byte_q;
      if (clk_en_i) begin
         rx_s1_d     = {link.ul_frame, link.ul_data};
         rx_s2_d     = rx_s1_q;
         // Fixed transceiver latency
         rx_fix_d[0] = rx_s2_q; // see [RL2]
         for (int i = 1; i < RX_FIXED; i++) begin
            rx_fix_d[i] = rx_fix_q[i-1];
         end
         rx_eb_d[0]  = rx_fix_q[RX_FIXED-1];
         rx_cal_d[0] = rx_by_out;
         for (int i = 1; i < DEPTH; i++) begin
            rx_eb_d[i]  = rx_eb_q[i-1];
            rx_cal_d[i] = rx_cal_q[i-1];
         end
         rx_byte_d = rx_eb_out;
         byte_d    = byte_ofs_i;
         // Line frame start to aux frame start
         aux_d     = rx_cal_out; // see [RL8]
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_s1_q   <= '0;
         rx_s2_q   <= '0;
         rx_fix_q  <= '0;
         rx_eb_q   <= '0;
         rx_byte_q <= '0;
         rx_cal_q  <= '0;
         aux_q     <= '0;
         byte_q    <= 2'h0;
      end else begin
         rx_s1_q   <= rx_s1_d;
         rx_s2_q   <= rx_s2_d;
         rx_fix_q  <= rx_fix_d;
         rx_eb_q   <= rx_eb_d;
         rx_byte_q <= rx_byte_d;
         rx_cal_q  <= rx_cal_d;
         aux_q     <= aux_d;
         byte_q    <= byte_d;
      end
   end

   assign aux_rx_data_o  = aux_q[`PDM_DATA_W-1:0];
   assign aux_rx_frame_o = aux_q[`PDM_DATA_W];
   assign byte_delay_o   = byte_q;

   // ****************************************
   // Round-trip measurement
   // ****************************************
   pdm_rt_state_t    st_q, st_d;
   logic [RTD_W-1:0] cnt_q, cnt_d, rtd_q, rtd_d;
   logic             vld_q, vld_d;
   logic             tx_sap, rx_sap;

   assign tx_sap = tx_line_d[`PDM_DATA_W] && clk_en_i;
   assign rx_sap = aux_d[`PDM_DATA_W] && clk_en_i;

   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      rtd_d = rtd_q;
      vld_d = vld_q;
      if (clk_en_i) begin
         vld_d = 1'b0;
         case (st_q)
            PDM_RT_IDLE: begin
               if (tx_sap && role_i == PDM_ROLE_MASTER) begin // see [RL10]
                  cnt_d = '0;
                  st_d  = PDM_RT_COUNT;
               end
            end
            PDM_RT_COUNT: begin
               // Whole core cycles, saturating
               if (cnt_q != '1) begin
                  cnt_d = cnt_q + 1'b1; // see [RL12] [RL15]
               end
               if (rx_sap) begin
                  st_d = PDM_RT_DONE;
               end
            end
            PDM_RT_DONE: begin
               // One update per measured frame
               rtd_d = cnt_q; // see [RL10] [RL15]
               vld_d = 1'b1;
               st_d  = PDM_RT_IDLE;
            end
            default: begin
               st_d = PDM_RT_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q  <= PDM_RT_IDLE;
         cnt_q <= '0;
         rtd_q <= `PDM_RTD_RESET;
         vld_q <= 1'b0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
         rtd_q <= rtd_d;
         vld_q <= vld_d;
      end
   end

   assign round_trip_delay_o = rtd_q;
   assign round_trip_valid_o = vld_q;

endmodule

/* bench/pdm_link_chk.sv */
// Concurrent checks on the link joining the endpoint and its partner.
// Assumes one shared clock, async active-low reset, enable dropped only when idle.
`timescale 1ns/1ps
`include "pdm_consts.svh"
module pdm_link_chk (
   // Clock and reset
   input  wire logic                   clk_sys_i,
   input  wire logic                   reset_n_i,
   // Link
   input  wire logic [`PDM_DATA_W-1:0] dl_data,
   input  wire logic                   dl_frame,
   input  wire logic [`PDM_DATA_W-1:0] ul_data,
   input  wire logic                   ul_frame
);
   logic [2:0] gap_q;
   logic [2:0] gap_d;

   // ****************************************
   // Cycles since last downlink frame
   // ****************************************
   always_comb begin
      gap_d = gap_q;
      if (dl_frame) gap_d = 3'h1;
      else if (gap_q != 3'h7) gap_d = gap_q + 3'h1;
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) gap_q <= 3'h7;
      else gap_q <= gap_d;
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);

   loop_frame_a: assert property (
      dl_frame |-> ##2 ul_frame) else $error("frame not looped back");
   loop_quiet_a: assert property (
      !dl_frame |-> ##2 !ul_frame) else $error("spurious uplink frame");
   loop_data_a: assert property (
      dl_frame |-> ##2 (ul_data == $past(dl_data, 2))) else $error("uplink word wrong");
   loop_word_a: assert property (
      !dl_frame |-> ##2 (ul_data == $past(dl_data, 2))) else $error("idle uplink word wrong");
   turn_count_a: assert property (
      $rose(ul_frame) |-> gap_q == 3'h2) else $error("turnaround not two cycles");
   loop_hold_a: assert property (
      ($stable(dl_data) && $stable(dl_frame)) |-> ##2 ($stable(ul_data) && $stable(ul_frame)))
      else $error("uplink moved while downlink still");

   frame_c: cover property (dl_frame ##2 ul_frame);
   rose_c: cover property ($rose(ul_frame));
   quiet_c: cover property (!dl_frame [*8]);
endmodule

/* bench/pdm_endpoint_test.sv */
// Self-checking bench: endpoint and partner joined by the link interface.
// Assumes the design files and the link checker are compiled first.
`timescale 1ns/1ps
`include "pdm_consts.svh"
module pdm_endpoint_test
   import pdm_pkg::*;
;
   logic                   clk_sys_i;
   logic                   reset_n_i;
   pdm_role_t              role;
   logic                   st_en, rt_en;
   logic [`PDM_CAL_W-1:0]  st_d, rt_d, tx_e, rx_e, bs_d;
   logic [1:0]             byte_ofs;
   logic [`PDM_DATA_W-1:0] aux_tx_data_i, aux_rx_data_o, prt_rx_data;
   logic                   aux_tx_frame_i, aux_rx_frame_o, prt_rx_frame;
   logic [1:0]             byte_delay_o;
   logic [`PDM_RTD_W-1:0]  round_trip_delay_o;
   logic                   round_trip_valid_o;
   int                     num_errors, checks_done, cycles, seq;
   logic                   clk_en;

   pdm_link_if link();

   pdm_endpoint pdm_endpoint_inst (
      .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en),
      .role_i(role), .st_cal_en_i(st_en), .rt_cal_en_i(rt_en),
      .st_cal_dly_i(st_d), .rt_cal_dly_i(rt_d), .tx_ebuf_dly_i(tx_e),
      .rx_ebuf_dly_i(rx_e), .bitslip_dly_i(bs_d), .byte_ofs_i(byte_ofs),
      .aux_tx_data_i(aux_tx_data_i), .aux_tx_frame_i(aux_tx_frame_i),
      .aux_rx_data_o(aux_rx_data_o), .aux_rx_frame_o(aux_rx_frame_o),
      .byte_delay_o(byte_delay_o), .round_trip_delay_o(round_trip_delay_o),
      .round_trip_valid_o(round_trip_valid_o), .link(link));

   pdm_partner pdm_partner_inst (
      .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en),
      .link(link), .rx_data_o(prt_rx_data), .rx_frame_o(prt_rx_frame));

   pdm_link_chk pdm_link_chk_inst (
      .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .dl_data(link.dl_data),
      .dl_frame(link.dl_frame), .ul_data(link.ul_data), .ul_frame(link.ul_frame));

   // ****************************************
   // Clock and timeout
   // ****************************************
   initial begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end

   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 4000) begin
         num_errors++;
         complete_run();
      end
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input bit ok, input string what);
      checks_done++;
      if (!ok) begin
         num_errors++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic set_cfg(input pdm_role_t r, input logic se, input logic re,
                          input int sd, input int rd, input int te, input int xe,
                          input int bd, input int bo);
      role = r;
      st_en = se;
      rt_en = re;
      st_d = sd[3:0];
      rt_d = rd[3:0];
      tx_e = te[3:0];
      rx_e = xe[3:0];
      bs_d = bd[3:0];
      byte_ofs = bo[1:0];
      repeat (4) @(negedge clk_sys_i);
   endtask

   task automatic send_frame(input int exp_tx, input int exp_rx, input bit mst);
      logic [`PDM_DATA_W-1:0] word;
      int t_at;
      int r_at;
      bit seen;
      word = 32'ha5a50000 + seq;
      seq++;
      t_at = -1;
      r_at = -1;
      seen = 1'b0;
      aux_tx_data_i = word;
      aux_tx_frame_i = 1'b1;
      for (int k = 1; k < 60 && r_at < 0; k++) begin
         @(negedge clk_sys_i);
         aux_tx_frame_i = 1'b0;
         aux_tx_data_i = ~word;
         if (k == t_at + 1) check(prt_rx_frame === 1'b1 && prt_rx_data === word, "partner copy");
         if (t_at < 0 && link.dl_frame === 1'b1) begin
            t_at = k;
            check(link.dl_data === word, "downlink word");
         end
         if (aux_rx_frame_o === 1'b1) begin
            r_at = k;
            check(aux_rx_data_o === word, "receive word");
         end
      end
      repeat (4) begin
         @(negedge clk_sys_i);
         if (round_trip_valid_o === 1'b1) begin
            seen = 1'b1;
            check(round_trip_delay_o === `PDM_RTD_W'(exp_rx), "round trip");
         end
      end
      check(t_at == exp_tx, "transmit delay");
      check(r_at - t_at == exp_rx, "receive delay");
      check(seen == mst, "round trip pulse");
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_base();
      set_cfg(PDM_ROLE_SLAVE, 1'b0, 1'b0, 0, 0, 2, 3, 5, 0);
      check(byte_delay_o === 2'h0, "byte flag idle");
      send_frame(6, 12, 1'b0);
      $display("test base done");
   endtask

   task automatic t_byte();
      for (int bo = 1; bo < 4; bo++) begin
         set_cfg(PDM_ROLE_SLAVE, 1'b0, 1'b0, 0, 0, 0, 0, 0, bo);
         check(byte_delay_o === bo[1:0], "byte flag");
         send_frame(4, 10, 1'b0);
      end
      $display("test byte done");
   endtask

   task automatic t_cal();
      set_cfg(PDM_ROLE_SLAVE, 1'b1, 1'b1, 3, 5, 0, 0, 0, 0);
      send_frame(4, 12, 1'b0);
      set_cfg(PDM_ROLE_MASTER, 1'b1, 1'b1, 3, 5, 0, 0, 0, 0);
      send_frame(4, 14, 1'b1);
      set_cfg(PDM_ROLE_RE_SLAVE, 1'b0, 1'b1, 0, 5, 0, 0, 6, 0);
      send_frame(10, 9, 1'b0);
      $display("test cal done");
   endtask

   task automatic t_master();
      logic [`PDM_RTD_W-1:0] first;
      int                    diff;
      int                    chain;
      int                    router_transit_delay;
      router_transit_delay = 3;
      set_cfg(PDM_ROLE_MASTER, 1'b0, 1'b0, 0, 0, 1, 2, 4, 2);
      send_frame(5, 12, 1'b1);
      first = round_trip_delay_o;
      send_frame(5, 12, 1'b1);
      // Periodic reads stay within the bound
      diff = int'(round_trip_delay_o) - int'(first);
      check(diff <= `PDM_RT_ACCURACY_CYC && diff >= -`PDM_RT_ACCURACY_CYC, "drift");
      // Two hops, inner two-cycle loopback removed
      chain = int'(first) + int'(round_trip_delay_o) + 2 * router_transit_delay - 2;
      check(chain == 22 + 2 * router_transit_delay, "chain sum");
      $display("test master done");
   endtask

   task automatic t_hold();
      bit moved;
      moved = 1'b0;
      set_cfg(PDM_ROLE_MASTER, 1'b0, 1'b0, 0, 0, 1, 2, 4, 2);
      clk_en = 1'b0;
      byte_ofs = 2'h1;
      aux_tx_frame_i = 1'b1;
      repeat (3) begin
         @(negedge clk_sys_i);
         aux_tx_frame_i = 1'b0;
         moved = moved | (byte_delay_o !== 2'h2);
      end
      check(!moved, "frozen byte flag");
      clk_en = 1'b1;
      repeat (8) begin
         @(negedge clk_sys_i);
         moved = moved | (link.dl_frame !== 1'b0) | (round_trip_valid_o !== 1'b0);
      end
      check(!moved, "frame taken while frozen");
      check(byte_delay_o === 2'h1, "byte flag after freeze");
      $display("test hold done");
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      reset_n_i = 1'b0;
      clk_en = 1'b1;
      aux_tx_data_i = 32'h00000000;
      aux_tx_frame_i = 1'b0;
      role = PDM_ROLE_SLAVE;
      st_en = 1'b0;
      rt_en = 1'b0;
      {st_d, rt_d, tx_e, rx_e, bs_d} = 20'h00000;
      byte_ofs = 2'h0;
      repeat (16) @(negedge clk_sys_i);
      reset_n_i = 1'b1;
      @(negedge clk_sys_i);
      t_base();
      t_byte();
      t_cal();
      t_master();
      t_hold();
      complete_run();
   end
endmodule
